// ---- core/tliv_pkg.sv ----
package tliv_pkg;
   // ==========================================
   // vectors
   localparam logic [15:0] VEC_HIGH           = 16'h0008;
   localparam logic [15:0] VEC_LOW            = 16'h0018;
   // ==========================================
   // register map (word index)
   localparam logic [3:0]  ADDR_GLOBAL_CTRL   = 4'h0;
   localparam logic [3:0]  ADDR_RESET_CTRL    = 4'h1;
   localparam logic [3:0]  ADDR_FLAG          = 4'h2;
   localparam logic [3:0]  ADDR_ENABLE        = 4'h3;
   localparam logic [3:0]  ADDR_PRIORITY      = 4'h4;
   localparam logic [3:0]  ADDR_PERIPH        = 4'h5;
   localparam logic [3:0]  ADDR_STATUS        = 4'h6;
   // ==========================================
   // global and reset control fields
   localparam int          BIT_GIE_HIGH       = 7;
   localparam int          BIT_GIE_LOW        = 6;
   localparam int          BIT_PRIO_MODE      = 7;
   // ==========================================
   // reset values
   localparam logic [7:0]  RST_GLOBAL_CTRL    = 8'h00;
   localparam logic [7:0]  RST_RESET_CTRL     = 8'h00;
   localparam logic [7:0]  RST_FLAG           = 8'h00;
   localparam logic [7:0]  RST_ENABLE         = 8'h00;
   localparam logic [7:0]  RST_PRIORITY       = 8'hFF;
   localparam logic [7:0]  RST_PERIPH         = 8'hF8;
   // ==========================================
   // timing, in instruction cycles (one clock each here)
   localparam int          SYNC_STAGES        = 3;
   localparam int          ACCEPT_DELAY       = 1;
   // ==========================================
   // service states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_LOW  = 3'b010,
      ST_HIGH = 3'b100
   } tliv_state_t;
endpackage : tliv_pkg

// ---- core/tliv_sync.sv ----
`timescale 1ns/1ps
module tliv_sync #(
   parameter int W = 8
) (
   input  wire logic         i_clk_sys,
   input  wire logic         i_reset,
   input  wire logic [W-1:0] i_async,
   output logic      [W-1:0] o_level,
   output logic      [W-1:0] o_change
);
   // ==========================================
   // three stages; a change counts when stages two and three agree
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;
   logic [W-1:0] lvl_q;
   wire  [W-1:0] agree_w = ~(s2_q ^ s3_q);
   wire  [W-1:0] lvl_d   = (agree_w & s3_q) | (~agree_w & lvl_q);

   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         s1_q  <= '0;
         s2_q  <= '0;
         s3_q  <= '0;
         lvl_q <= '0;
      end else begin
         s1_q  <= i_async;
         s2_q  <= s1_q;
         s3_q  <= s2_q;
         lvl_q <= lvl_d;
      end
   end

   assign o_level  = lvl_q;
   assign o_change = lvl_q ^ lvl_d;
endmodule : tliv_sync

// ---- core/tliv_edge.sv ----
`timescale 1ns/1ps
module tliv_edge #(
   parameter int W = 4
) (
   input  wire logic         i_clk_sys,
   input  wire logic         i_reset,
   input  wire logic [W-1:0] i_level,
   input  wire logic [W-1:0] i_change,
   input  wire logic [W-1:0] i_rising,
   output logic      [W-1:0] o_event
);
   // ==========================================
   // edge select per external pin, one-cycle event out
   logic [W-1:0] evt_d;

   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_edge
         // i_change marks a level about to flip, so the new level is ~i_level
         assign evt_d[g] = i_change[g] & (i_level[g] != i_rising[g]);
      end
   endgenerate

   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         o_event <= '0;
      end else begin
         o_event <= evt_d;
      end
   end
endmodule : tliv_edge

// ---- core/tliv_intc.sv ----
`timescale 1ns/1ps
// Function
// - high vector 0008h, low vector 0018h
// - high request pre-empts low routine
// - each source: flag, enable, priority bit
// - priority mode only when bit 7 set
// - bit 7 gates high, bit 6 low
// - flag, enable, global set: vector now
// - priority mode resets off; priorities ignored
// - compat: bit 6 peripherals, bit 7 all
// - compat: every vector goes to 0008h
// - accept clears matching global enable
// - high routine holds off low requests
// - core pushes return, loads vector
// - all flags stay readable
// - return sets enable of exited level
// - external latency five to six cycles
// - flag set regardless of enables
// - clearing one enable stops one source
// - hardware never clears a flag
module tliv_intc #(
   parameter int N_SRC = 8,
   parameter int N_EXT = 4
) (
   input  wire logic             i_clk_sys,
   input  wire logic             i_reset,
   input  wire logic [3:0]       i_addr,
   input  wire logic [7:0]       i_wdata,
   input  wire logic             i_wr,
   input  wire logic             i_rd,
   output logic      [7:0]       o_rdata,
   input  wire logic [N_EXT-1:0] i_ext_pin,
   input  wire logic [N_SRC-1:0] i_periph_event,
   input  wire logic             i_return_from_interrupt,
   input  wire logic             i_vector_taken,
   output logic                  o_vector_req,
   output logic      [15:0]      o_vector_addr,
   output logic      [2:0]       o_service_state
);
   // ==========================================
   // sources: [N_EXT-1:0] external pins or peripheral inputs, rest peripheral inputs only
   // external pins occupy the low flag bits; peripheral events OR in
   localparam int W = N_SRC;

   logic [7:0] gctl_q;
   logic [7:0] rctl_q;
   logic [W-1:0] flag_q;
   logic [W-1:0] en_q;
   logic [W-1:0] prio_q;
   logic [W-1:0] periph_q;
   logic [N_EXT-1:0] edge_q;
   logic [7:0] rdata_q;
   logic req_q;
   logic [15:0] vec_q;
   logic acc_high_q;
   logic [N_EXT-1:0] pin_lvl;
   logic [N_EXT-1:0] pin_chg;
   logic [N_EXT-1:0] ext_evt;
   tliv_pkg::tliv_state_t st_q;
   tliv_pkg::tliv_state_t st_d;

   tliv_sync #(.W(N_EXT)) u_sync (
      .i_clk_sys (i_clk_sys),
      .i_reset   (i_reset),
      .i_async   (i_ext_pin),
      .o_level   (pin_lvl),
      .o_change  (pin_chg)
   );

   tliv_edge #(.W(N_EXT)) u_edge (
      .i_clk_sys (i_clk_sys),
      .i_reset   (i_reset),
      .i_level   (pin_lvl),
      .i_change  (pin_chg),
      .i_rising  (edge_q),
      .o_event   (ext_evt)
   );

   // ==========================================
   // decode
   function automatic logic hit(input logic [3:0] a, input logic [3:0] want);
      hit = (a == want);
   endfunction : hit

   wire wr_gctl  = i_wr & hit(i_addr, tliv_pkg::ADDR_GLOBAL_CTRL);
   wire wr_rctl  = i_wr & hit(i_addr, tliv_pkg::ADDR_RESET_CTRL);
   wire wr_flag  = i_wr & hit(i_addr, tliv_pkg::ADDR_FLAG);
   wire wr_en    = i_wr & hit(i_addr, tliv_pkg::ADDR_ENABLE);
   wire wr_prio  = i_wr & hit(i_addr, tliv_pkg::ADDR_PRIORITY);
   wire wr_per   = i_wr & hit(i_addr, tliv_pkg::ADDR_PERIPH);
   wire wr_edge  = i_wr & hit(i_addr, tliv_pkg::ADDR_STATUS);

   wire prio_mode = rctl_q[tliv_pkg::BIT_PRIO_MODE];
   wire gie_h     = gctl_q[tliv_pkg::BIT_GIE_HIGH];
   wire gie_l     = gctl_q[tliv_pkg::BIT_GIE_LOW];

   // ==========================================
   // arbitration
   wire [W-1:0] event_in;
   assign event_in = i_periph_event | W'(ext_evt);
   wire [W-1:0] active   = flag_q & en_q;
   wire [W-1:0] act_hi   = active & prio_q;
   wire [W-1:0] act_lo   = active & ~prio_q;
   wire         pend_hi  = (|act_hi) & gie_h;
   wire         pend_lo  = (|act_lo) & gie_l;
   wire         pend_cmp = gie_h & (|(active & ~periph_q)
                           | (gie_l & |(active & periph_q)));
   // high routine blocks low; low routine can be pre-empted by high
   wire take_hi  = prio_mode & pend_hi & (st_q != tliv_pkg::ST_HIGH);
   wire take_lo  = prio_mode & pend_lo & ~pend_hi
                   & (st_q == tliv_pkg::ST_IDLE);
   wire take_cmp = ~prio_mode & pend_cmp & (st_q == tliv_pkg::ST_IDLE);
   wire accept   = ~req_q & (take_hi | take_lo | take_cmp);
   wire acc_high = take_hi | take_cmp;
   wire [15:0] vec_d = acc_high ? tliv_pkg::VEC_HIGH
                                : tliv_pkg::VEC_LOW;

   // ==========================================
   // service state: which level is being served
   always_comb begin
      st_d = st_q;
      if (accept) begin
         st_d = acc_high ? tliv_pkg::ST_HIGH : tliv_pkg::ST_LOW;
      end else if (i_return_from_interrupt) begin
         unique case (st_q)
            tliv_pkg::ST_HIGH: st_d = prio_mode & ~gie_l ? tliv_pkg::ST_LOW
                                                         : tliv_pkg::ST_IDLE;
            tliv_pkg::ST_LOW:  st_d = tliv_pkg::ST_IDLE;
            tliv_pkg::ST_IDLE: st_d = tliv_pkg::ST_IDLE;
            default:           st_d = tliv_pkg::ST_IDLE;
         endcase
      end
   end

   // ==========================================
   // global enables: software write, clear on accept, set on return
   logic [7:0] gctl_d;
   always_comb begin
      gctl_d = wr_gctl ? i_wdata : gctl_q;
      if (accept) begin
         if (!prio_mode || acc_high) begin
            gctl_d[tliv_pkg::BIT_GIE_HIGH] = 1'b0;
         end else begin
            gctl_d[tliv_pkg::BIT_GIE_LOW] = 1'b0;
         end
      end else if (i_return_from_interrupt) begin
         if (!prio_mode || st_q == tliv_pkg::ST_HIGH) begin
            gctl_d[tliv_pkg::BIT_GIE_HIGH] = 1'b1;
         end else begin
            gctl_d[tliv_pkg::BIT_GIE_LOW] = 1'b1;
         end
      end
   end

   // flags: events set, software clears; set wins, no hardware clear
   wire [W-1:0] flag_d = (wr_flag ? i_wdata[W-1:0] : flag_q) | event_in;

   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         gctl_q <= tliv_pkg::RST_GLOBAL_CTRL;
         rctl_q <= tliv_pkg::RST_RESET_CTRL;
         flag_q <= W'(tliv_pkg::RST_FLAG);
         en_q   <= W'(tliv_pkg::RST_ENABLE);
         prio_q <= W'(tliv_pkg::RST_PRIORITY);
         periph_q <= W'(tliv_pkg::RST_PERIPH);
         edge_q <= '1;
         st_q   <= tliv_pkg::ST_IDLE;
      end else begin
         gctl_q <= gctl_d;
         flag_q <= flag_d;
         st_q   <= st_d;
         if (wr_rctl) rctl_q <= i_wdata;
         if (wr_en)   en_q   <= i_wdata[W-1:0];
         if (wr_prio) prio_q <= i_wdata[W-1:0];
         if (wr_per)  periph_q <= i_wdata[W-1:0];
         if (wr_edge) edge_q <= i_wdata[N_EXT-1:0];
      end
   end

   // ==========================================
   // vector request held until the core takes it
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         req_q      <= 1'b0;
         vec_q      <= tliv_pkg::VEC_HIGH;
         acc_high_q <= 1'b0;
      end else if (accept) begin
         req_q      <= 1'b1;
         vec_q      <= vec_d;
         acc_high_q <= acc_high;
      end else if (i_vector_taken) begin
         req_q      <= 1'b0;
      end
   end

   // ==========================================
   // read port, data one cycle after strobe
   logic [7:0] rsel;
   always_comb begin
      rsel = 8'h00;
      unique case (i_addr)
         tliv_pkg::ADDR_GLOBAL_CTRL: rsel = gctl_q;
         tliv_pkg::ADDR_RESET_CTRL:  rsel = rctl_q;
         tliv_pkg::ADDR_FLAG:        rsel = 8'(flag_q);
         tliv_pkg::ADDR_ENABLE:      rsel = 8'(en_q);
         tliv_pkg::ADDR_PRIORITY:    rsel = 8'(prio_q);
         tliv_pkg::ADDR_PERIPH:      rsel = 8'(periph_q);
         tliv_pkg::ADDR_STATUS:      rsel = {acc_high_q, req_q, st_q, 3'(edge_q)};
         default:                    rsel = 8'h00;
      endcase
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= i_rd ? rsel : 8'h00;
      end
   end

   assign o_rdata         = rdata_q;
   assign o_vector_req    = req_q;
   assign o_vector_addr   = vec_q;
   assign o_service_state = st_q;

   // ==========================================
   // checks
   // request raised with the vector chosen one cycle earlier
   sequence s_vector_up;
      req_q ##0 vec_q == $past(vec_d);
   endsequence

   AST_COMPAT_VEC: assert property (@(posedge i_clk_sys) disable iff (i_reset)
      accept && !prio_mode |=> vec_q == tliv_pkg::VEC_HIGH)
      else $error("compat vector not 0008h");
   AST_LOW_VEC: assert property (@(posedge i_clk_sys) disable iff (i_reset)
      take_lo && accept |=> vec_q == tliv_pkg::VEC_LOW)
      else $error("low vector not 0018h");
   AST_HIGH_FIRST: assert property (@(posedge i_clk_sys) disable iff (i_reset)
      accept && prio_mode && pend_hi |=> acc_high_q)
      else $error("low accepted over high");
   AST_HOLD_LOW: assert property (@(posedge i_clk_sys) disable iff (i_reset)
      st_q == tliv_pkg::ST_HIGH && !req_q |=> !(req_q && vec_q == tliv_pkg::VEC_LOW))
      else $error("low taken in high routine");
   AST_CLR_GIE: assert property (@(posedge i_clk_sys) disable iff (i_reset)
      accept && acc_high && !wr_gctl |=> !gie_h)
      else $error("global enable not cleared");
   AST_RET_SET: assert property (@(posedge i_clk_sys) disable iff (i_reset)
      i_return_from_interrupt && !accept && !prio_mode && !wr_gctl |=> gie_h)
      else $error("return did not re-enable");
   AST_FLAG_SET: assert property (@(posedge i_clk_sys) disable iff (i_reset)
      |event_in |=> (flag_q & $past(event_in)) == $past(event_in))
      else $error("event flag lost");
   AST_NO_AUTO_CLR: assert property (@(posedge i_clk_sys) disable iff (i_reset)
      !wr_flag |=> (flag_q & $past(flag_q)) == $past(flag_q))
      else $error("flag cleared by hardware");
   AST_PREEMPT: assert property (@(posedge i_clk_sys) disable iff (i_reset)
      st_q == tliv_pkg::ST_LOW && prio_mode && pend_hi && !req_q
      |=> st_q == tliv_pkg::ST_HIGH ##0 s_vector_up)
      else $error("high did not pre-empt low");
   AST_LATENCY: assert property (@(posedge i_clk_sys) disable iff (i_reset)
      accept |=> s_vector_up)
      else $error("vector not raised after accept");
endmodule : tliv_intc

// ---- test/tliv_core_model.sv ----
`timescale 1ns/1ps
module tliv_core_model (
   input  wire logic        i_clk_sys,
   input  wire logic        i_reset,
   input  wire logic        i_vector_req,
   input  wire logic [15:0] i_vector_addr,
   input  wire logic        i_slow,
   output logic             o_vector_taken,
   output logic      [15:0] o_last_addr,
   output int               o_n_taken
);
   int wait_cnt;
   // ==========================================
   // fetch and stack side of the core
   // slow mode models a three-cycle instruction finishing before the push
   always @(posedge i_clk_sys) begin
      if (i_reset) begin
         o_vector_taken <= 1'b0;
         o_last_addr    <= 16'h0000;
         o_n_taken      <= 0;
         wait_cnt       <= 0;
      end else if (i_vector_req && !o_vector_taken && wait_cnt >= (i_slow ? 3 : 0)) begin
         o_vector_taken <= 1'b1;
         o_last_addr    <= i_vector_addr;
         o_n_taken      <= o_n_taken + 1;
         wait_cnt       <= 0;
      end else begin
         o_vector_taken <= 1'b0;
         wait_cnt       <= i_vector_req ? wait_cnt + 1 : 0;
      end
   end
endmodule : tliv_core_model

// ---- test/testbench.sv ----
`timescale 1ns/1ps
module testbench;
   // ==========================================
   // signals
   localparam logic [3:0] A_GC = tliv_pkg::ADDR_GLOBAL_CTRL;
   localparam logic [3:0] A_RC = tliv_pkg::ADDR_RESET_CTRL;
   localparam logic [3:0] A_FL = tliv_pkg::ADDR_FLAG;
   localparam logic [3:0] A_EN = tliv_pkg::ADDR_ENABLE;
   localparam logic [3:0] A_PR = tliv_pkg::ADDR_PRIORITY;
   logic        i_clk_sys      = 1'b0;
   logic        i_reset        = 1'b1;
   logic [3:0]  i_addr         = 4'h0;
   logic [7:0]  i_wdata        = 8'h00;
   logic        i_wr           = 1'b0;
   logic        i_rd           = 1'b0;
   logic [3:0]  i_ext_pin      = 4'h0;
   logic [7:0]  i_periph_event = 8'h00;
   logic        i_ret          = 1'b0;
   logic        slow           = 1'b0;
   logic        taken;
   logic        o_vector_req;
   logic [15:0] o_vector_addr;
   logic [2:0]  o_service_state;
   logic [7:0]  o_rdata;
   logic [15:0] last_addr;
   logic [7:0]  ev;
   int          n_taken;
   int          err_total      = 0;
   int          n_tests        = 0;
   int          seed           = 32'hb72b;
   int          lat;

   initial forever #4 i_clk_sys = ~i_clk_sys;

   tliv_intc #(.N_SRC(8), .N_EXT(4)) i_dut (
      .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_ext_pin(i_ext_pin),
      .i_periph_event(i_periph_event), .i_return_from_interrupt(i_ret),
      .i_vector_taken(taken), .o_vector_req(o_vector_req), .o_vector_addr(o_vector_addr),
      .o_service_state(o_service_state));

   tliv_core_model i_core (
      .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_vector_req(o_vector_req),
      .i_vector_addr(o_vector_addr), .i_slow(slow), .o_vector_taken(taken),
      .o_last_addr(last_addr), .o_n_taken(n_taken));

   // ==========================================
   // helpers
   function automatic logic [15:0] exp_vec(input logic pm, input logic hi);
      return (pm && !hi) ? tliv_pkg::VEC_LOW : tliv_pkg::VEC_HIGH;
   endfunction : exp_vec

   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : print_verdict

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge i_clk_sys);
      i_wr    <= 1'b1;
      i_addr  <= a;
      i_wdata <= d;
      @(posedge i_clk_sys);
      i_wr    <= 1'b0;
   endtask : wr

   task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
      @(posedge i_clk_sys);
      i_rd   <= 1'b1;
      i_addr <= a;
      @(posedge i_clk_sys);
      i_rd   <= 1'b0;
      #1 check(16'(o_rdata), 16'(e));
   endtask : rd_chk

   task automatic pulse(input logic [7:0] e);
      @(posedge i_clk_sys);
      i_periph_event <= e;
      @(posedge i_clk_sys);
      i_periph_event <= 8'h00;
   endtask : pulse

   task automatic ret;
      @(posedge i_clk_sys);
      i_ret <= 1'b1;
      @(posedge i_clk_sys);
      i_ret <= 1'b0;
   endtask : ret

   task automatic no_vec;
      int n0;
      n0 = n_taken;
      repeat (12) @(negedge i_clk_sys);
      check(16'(n_taken - n0), 16'h0000);
   endtask : no_vec

   // a vector that never comes ends the run rather than hanging it
   task automatic expect_vec(input logic [15:0] a);
      int n0;
      n0 = n_taken;
      repeat (20) if (n_taken == n0) @(negedge i_clk_sys);
      if (n_taken == n0) begin
         err_total++;
         print_verdict();
      end
      check(last_addr, a);
   endtask : expect_vec

   task automatic done(input string s);
      $display("test %s finished", s);
   endtask : done

   // ==========================================
   // main sequence
   initial begin
      repeat (6) @(posedge i_clk_sys);
      i_reset <= 1'b0;
      rd_chk(A_GC, tliv_pkg::RST_GLOBAL_CTRL);
      rd_chk(A_RC, tliv_pkg::RST_RESET_CTRL);
      rd_chk(A_FL, tliv_pkg::RST_FLAG);
      rd_chk(A_EN, tliv_pkg::RST_ENABLE);
      rd_chk(A_PR, tliv_pkg::RST_PRIORITY);
      rd_chk(tliv_pkg::ADDR_PERIPH, tliv_pkg::RST_PERIPH);
      rd_chk(4'hF, 8'h00);
      done("reset");
      for (int i = 0; i < 6; i++) begin
         ev = 8'($random(seed));
         pulse(ev);
         rd_chk(A_FL, ev);
         ev = 8'($random(seed));
         wr(A_FL, ev);
         rd_chk(A_FL, ev);
         wr(A_FL, 8'h00);
      end
      no_vec();
      done("random flags");
      wr(A_PR, 8'h00);
      wr(A_EN, 8'h01);
      wr(A_GC, 8'h80);
      pulse(8'h01);
      expect_vec(exp_vec(1'b0, 1'b0));
      rd_chk(A_GC, 8'h00);
      rd_chk(A_FL, 8'h01);
      wr(A_FL, 8'h00);
      ret();
      rd_chk(A_GC, 8'h80);
      wr(A_EN, 8'h08);
      pulse(8'h08);
      no_vec();
      slow = 1'b1;
      wr(A_GC, 8'hC0);
      expect_vec(tliv_pkg::VEC_HIGH);
      wr(A_FL, 8'h00);
      ret();
      rd_chk(A_GC, 8'hC0);
      done("compatibility");
      wr(A_EN, 8'h01);
      @(posedge i_clk_sys);
      i_ext_pin <= 4'h1;
      lat = 0;
      do begin
         @(negedge i_clk_sys);
         lat++;
      end while (o_vector_req !== 1'b1 && lat < 20);
      check(16'(lat >= 3 && lat <= 8), 16'h0001);
      if (o_vector_req !== 1'b1) print_verdict();
      expect_vec(tliv_pkg::VEC_HIGH);
      wr(A_FL, 8'h00);
      ret();
      // falling edge selected on every pin; the pin now returns low
      wr(tliv_pkg::ADDR_STATUS, 8'h00);
      rd_chk(tliv_pkg::ADDR_STATUS, 8'h88);
      @(posedge i_clk_sys);
      i_ext_pin <= 4'h0;
      expect_vec(tliv_pkg::VEC_HIGH);
      wr(A_FL, 8'h00);
      ret();
      done("external pin");
      wr(A_RC, 8'h80);
      rd_chk(A_RC, 8'h80);
      wr(A_PR, 8'h01);
      wr(A_EN, 8'h03);
      wr(A_GC, 8'hC0);
      pulse(8'h02);
      expect_vec(exp_vec(1'b1, 1'b0));
      check(16'(o_service_state), 16'(tliv_pkg::ST_LOW));
      rd_chk(A_GC, 8'h80);
      slow = 1'b0;
      pulse(8'h01);
      expect_vec(exp_vec(1'b1, 1'b1));
      check(16'(o_service_state), 16'(tliv_pkg::ST_HIGH));
      rd_chk(A_GC, 8'h00);
      wr(A_GC, 8'h40);
      no_vec();
      wr(A_FL, 8'h02);
      ret();
      expect_vec(tliv_pkg::VEC_LOW);
      rd_chk(A_GC, 8'h80);
      wr(A_FL, 8'h00);
      ret();
      rd_chk(A_GC, 8'hC0);
      done("priority pre-emption");
      pulse(8'h03);
      expect_vec(tliv_pkg::VEC_HIGH);
      no_vec();
      wr(A_FL, 8'h00);
      ret();
      rd_chk(A_GC, 8'hC0);
      wr(A_EN, 8'h02);
      pulse(8'h01);
      no_vec();
      rd_chk(A_FL, 8'h01);
      wr(A_GC, 8'h40);
      wr(A_EN, 8'h03);
      no_vec();
      wr(A_GC, 8'hC0);
      expect_vec(tliv_pkg::VEC_HIGH);
      wr(A_FL, 8'h00);
      ret();
      rd_chk(A_GC, 8'hC0);
      done("gating");
      print_verdict();
   end
endmodule : testbench
